// [hw/ccr_cfg.svh]
/*
 * Constants of the charger control registers 5 to 7: offsets, reset
 * values, field positions, analog codes and timing figures.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

`define CCR_ADDR_TIMER_WD      8'h05
`define CCR_ADDR_PROTECT       8'h06
`define CCR_ADDR_SWITCH        8'h07
`define CCR_RST_TIMER_WD       8'hBF
`define CCR_RST_PROTECT        8'hE6
`define CCR_RST_SWITCH         8'h4C
`define CCR_RDATA_UNMAPPED     8'h00
// Bits of the switch register that survive watchdog expiry
`define CCR_SWITCH_WD_KEEP     8'h2B

// Timer and watchdog register fields
`define CCR_B_TERM_EN          7
`define CCR_B_DEGLITCH_SEL     6
`define CCR_F_WD_HI            5
`define CCR_F_WD_LO            4
`define CCR_B_TIMER_EN         3
`define CCR_B_TIMER_LEN        2
`define CCR_B_THERMAL_SEL      1
`define CCR_B_COLD_SEL         0
// Protection and boost register fields
`define CCR_F_OVP_HI           7
`define CCR_F_OVP_LO           6
`define CCR_F_BOOST_HI         5
`define CCR_F_BOOST_LO         4
`define CCR_F_FLOOR_HI         3
`define CCR_F_FLOOR_LO         0
// Switch and misc register fields
`define CCR_B_FORCE_DETECT     7
`define CCR_B_HALF_RATE        6
`define CCR_B_SW_DISABLE       5
`define CCR_B_WARM_SEL         4
`define CCR_B_SW_DELAY         3
`define CCR_B_SW_RST_EN        2
`define CCR_F_TRACK_HI         1
`define CCR_F_TRACK_LO         0

// Timing, base tick of 1 ms
`define CCR_CLK_MHZ            100
`define CCR_TICK_US            1000
`define CCR_DEGLITCH_LONG_MS   32'd230
`define CCR_DEGLITCH_SHORT_MS  32'd16
`define CCR_WD_40S_MS          32'd40000
`define CCR_WD_80S_MS          32'd80000
`define CCR_WD_160S_MS         32'd160000
`define CCR_SAFETY_7H_MS       32'd25200000
`define CCR_SAFETY_16H_MS      32'd57600000
`define CCR_SHIP_DELAY_MS      32'd12000

// Analog codes in millivolts, cold-zone current factors in percent
`define CCR_OVP_0_MV           16'd5500
`define CCR_OVP_1_MV           16'd6500
`define CCR_OVP_2_MV           16'd10500
`define CCR_OVP_3_MV           16'd14000
`define CCR_BOOST_0_MV         16'd4850
`define CCR_BOOST_1_MV         16'd5000
`define CCR_BOOST_2_MV         16'd5150
`define CCR_BOOST_3_MV         16'd5300
`define CCR_FLOOR_OS_0_MV      16'd3900
`define CCR_FLOOR_OS_1_MV      16'd5900
`define CCR_FLOOR_OS_2_MV      16'd7500
`define CCR_FLOOR_OS_3_MV      16'd10500
`define CCR_FLOOR_STEP_MV      16'd100
`define CCR_TRACK_1_MV         16'd200
`define CCR_TRACK_2_MV         16'd250
`define CCR_TRACK_3_MV         16'd300
`define CCR_WARM_LIMIT_MV      16'd4100
`define CCR_COLD_HALF_PCT      16'd50
`define CCR_COLD_FIFTH_PCT     16'd20
`define CCR_PCT_FULL           16'd100

`endif

// [hw/ccr_pkg.sv]
/*
 * Types shared by the charger control register block.
 * Assumes ccr_cfg.svh supplies all numeric constants.
 */
package ccr_pkg;
    typedef enum logic [1:0] {
        CCR_SHIP_IDLE,
        CCR_SHIP_WAIT,
        CCR_SHIP_OFF
    } ccr_ship_state_t;
    typedef logic [7:0]  ccr_byte_t;
    typedef logic [15:0] ccr_mv_t;
endpackage : ccr_pkg

// [hw/ccr_interval_counter.sv]
/*
 * Tick counter that raises done once run has held for limit ticks.
 * Assumes advance is a one-cycle tick on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module ccr_interval_counter #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         run,
    input  wire logic         advance,
    input  wire logic [W-1:0] limit,
    output var  logic         done
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         done_q;
    logic         done_d;

    always_comb
    begin
        count_d = count_q;
        if (!run)
            count_d = '0;
        else if (advance && count_q < limit)
            count_d = count_q + 1'b1;
        done_d = run && (count_d >= limit);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            done_q  <= done_d;
        end
    end

    assign done = done_q;
endmodule : ccr_interval_counter
`default_nettype wire

// [hw/ccr_control_regs.sv]
/*
 * Charger control registers 5 to 7 with their timers: termination
 * deglitch, host watchdog, charge safety timer, ship-mode delay,
 * forced input limit detection and decoded analog set points.
 * Assumes a serial front end that issues one-cycle register strobes,
 * and analog logic on this clock for zone, current and voltage inputs.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccr_cfg.svh"
module ccr_control_regs
    import ccr_pkg::*;
#(
    parameter int TICK_CYCLES = `CCR_TICK_US * `CCR_CLK_MHZ
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        reg_reset_cmd,
    input  wire logic        watchdog_kick,
    input  wire logic        vbus_present_pin,
    input  wire logic        term_condition_pin,
    input  wire logic        charging_active,
    input  wire logic        slow_condition,
    input  wire logic        detect_done,
    input  wire logic        cold_zone,
    input  wire logic        cold_zone_current_enable,
    input  wire logic        warm_zone,
    input  wire logic [15:0] ichg_ma,
    input  wire logic [15:0] vreg_mv,
    input  wire logic [15:0] vbat_mv,
    input  wire logic [1:0]  input_floor_offset_select,
    output var  logic        termination_done,
    output var  logic        watchdog_expired,
    output var  logic        safety_timer_expired,
    output var  logic        input_detect_run,
    output var  logic        battery_switch_off,
    output var  logic        battery_switch_reset_allowed,
    output var  logic        thermal_limit_select,
    output var  logic [15:0] ovp_threshold_mv,
    output var  logic [15:0] boost_mv,
    output var  logic [15:0] input_floor_mv,
    output var  logic [15:0] charge_current_ma,
    output var  logic [15:0] charge_voltage_mv
);
    ccr_byte_t       timer_wd_q, timer_wd_d;
    ccr_byte_t       protect_q, protect_d;
    ccr_byte_t       switch_q, switch_d;
    ccr_byte_t       rdata_q, rdata_d;
    logic [1:0]      vbus_sync_q, term_sync_q;
    logic [31:0]     tick_cnt_q, tick_cnt_d;
    logic            tick_q, tick_d;
    logic            half_phase_q, half_phase_d;
    logic            wd_fire_q, wd_fire_d;
    logic            detect_q, detect_d;
    ccr_ship_state_t ship_q, ship_d;
    ccr_mv_t         ovp_q, ovp_d, boost_q, boost_d, floor_q, floor_d;
    ccr_mv_t         cur_q, cur_d, volt_q, volt_d;
    logic            thermal_q, rst_allow_q;
    logic [31:0]     wd_limit, safety_limit, deglitch_limit, ship_limit;
    logic            wd_done, safety_done, deglitch_done, ship_done;
    logic            wd_run, safety_run, safety_adv, deglitch_run, ship_run;
    ccr_mv_t         floor_reg_mv, track_mv;
    logic [1:0]      wd_field;

    function automatic ccr_mv_t pick4(input logic [1:0] code, input ccr_mv_t v0,
                                      input ccr_mv_t v1, input ccr_mv_t v2,
                                      input ccr_mv_t v3);
        unique case (code)
            2'h0: pick4 = v0;
            2'h1: pick4 = v1;
            2'h2: pick4 = v2;
            2'h3: pick4 = v3;
        endcase
    endfunction : pick4

    // Pins from outside the clock domain
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vbus_sync_q <= 2'h0;
            term_sync_q <= 2'h0;
        end
        else
        begin
            vbus_sync_q <= {vbus_sync_q[0], vbus_present_pin};
            term_sync_q <= {term_sync_q[0], term_condition_pin};
        end
    end

    assign wd_field = timer_wd_q[`CCR_F_WD_HI:`CCR_F_WD_LO];

    // Timer limits in ms ticks
    always_comb
    begin
        unique case (wd_field)
            2'h1: wd_limit = `CCR_WD_40S_MS;
            2'h2: wd_limit = `CCR_WD_80S_MS;
            2'h3: wd_limit = `CCR_WD_160S_MS;
            2'h0: wd_limit = `CCR_WD_160S_MS;
        endcase
        safety_limit = timer_wd_q[`CCR_B_TIMER_LEN] ? `CCR_SAFETY_16H_MS
                                                    : `CCR_SAFETY_7H_MS;
        deglitch_limit = timer_wd_q[`CCR_B_DEGLITCH_SEL] ? `CCR_DEGLITCH_SHORT_MS
                                                         : `CCR_DEGLITCH_LONG_MS;
        ship_limit = `CCR_SHIP_DELAY_MS;
        // Kick and the expiry pulse both restart the count
        wd_run = (wd_field != 2'h0) && !watchdog_kick && !wd_fire_q;
        safety_run = timer_wd_q[`CCR_B_TIMER_EN] && charging_active;
        safety_adv = tick_q && (!(switch_q[`CCR_B_HALF_RATE] && slow_condition)
                                || half_phase_q);
        deglitch_run = timer_wd_q[`CCR_B_TERM_EN] && term_sync_q[1];
        ship_run = (ship_q == CCR_SHIP_WAIT);
    end

    // Base tick and half-rate phase
    always_comb
    begin
        tick_cnt_d = tick_cnt_q + 32'd1;
        tick_d = 1'b0;
        if (tick_cnt_q >= 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_d = 32'd0;
            tick_d = 1'b1;
        end
        half_phase_d = tick_q ? !half_phase_q : half_phase_q;
        wd_fire_d = wd_done && !wd_fire_q && (wd_field != 2'h0);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_cnt_q   <= 32'd0;
            tick_q       <= 1'b0;
            half_phase_q <= 1'b0;
            wd_fire_q    <= 1'b0;
        end
        else
        begin
            tick_cnt_q   <= tick_cnt_d;
            tick_q       <= tick_d;
            half_phase_q <= half_phase_d;
            wd_fire_q    <= wd_fire_d;
        end
    end

    ccr_interval_counter #(.W(32)) u_wd (
        .clk(clk), .reset_n(reset_n), .run(wd_run), .advance(tick_q),
        .limit(wd_limit), .done(wd_done)
    );
    ccr_interval_counter #(.W(32)) u_safety (
        .clk(clk), .reset_n(reset_n), .run(safety_run), .advance(safety_adv),
        .limit(safety_limit), .done(safety_done)
    );
    ccr_interval_counter #(.W(32)) u_deglitch (
        .clk(clk), .reset_n(reset_n), .run(deglitch_run), .advance(tick_q),
        .limit(deglitch_limit), .done(deglitch_done)
    );
    ccr_interval_counter #(.W(32)) u_ship (
        .clk(clk), .reset_n(reset_n), .run(ship_run), .advance(tick_q),
        .limit(ship_limit), .done(ship_done)
    );

    // Register file, register reset and watchdog restore
    always_comb
    begin
        timer_wd_d = timer_wd_q;
        protect_d  = protect_q;
        switch_d   = switch_q;
        rdata_d    = rdata_q;
        if (reg_write)
        begin
            unique case (reg_addr)
                `CCR_ADDR_TIMER_WD: timer_wd_d = reg_wdata;
                `CCR_ADDR_PROTECT:  protect_d  = reg_wdata;
                `CCR_ADDR_SWITCH:   switch_d   = reg_wdata;
                default: ;
            endcase
        end
        // Detection end clears the bit, a same-cycle write of 1 wins
        if (detect_done && switch_q[`CCR_B_FORCE_DETECT]
            && !(reg_write && reg_addr == `CCR_ADDR_SWITCH
                 && reg_wdata[`CCR_B_FORCE_DETECT]))
            switch_d[`CCR_B_FORCE_DETECT] = 1'b0;
        if (wd_fire_q)
        begin
            timer_wd_d = `CCR_RST_TIMER_WD;
            switch_d   = (switch_d & `CCR_SWITCH_WD_KEEP)
                       | (`CCR_RST_SWITCH & ~`CCR_SWITCH_WD_KEEP);
        end
        if (reg_reset_cmd)
        begin
            timer_wd_d = `CCR_RST_TIMER_WD;
            protect_d  = `CCR_RST_PROTECT;
            switch_d   = `CCR_RST_SWITCH;
        end
        if (reg_read)
        begin
            unique case (reg_addr)
                `CCR_ADDR_TIMER_WD: rdata_d = timer_wd_q;
                `CCR_ADDR_PROTECT:  rdata_d = protect_q;
                `CCR_ADDR_SWITCH:   rdata_d = switch_q;
                default:            rdata_d = `CCR_RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timer_wd_q <= `CCR_RST_TIMER_WD;
            protect_q  <= `CCR_RST_PROTECT;
            switch_q   <= `CCR_RST_SWITCH;
            rdata_q    <= `CCR_RDATA_UNMAPPED;
        end
        else
        begin
            timer_wd_q <= timer_wd_d;
            protect_q  <= protect_d;
            switch_q   <= switch_d;
            rdata_q    <= rdata_d;
        end
    end

    // Ship mode sequence; clearing the disable bit aborts or releases
    always_comb
    begin
        ship_d = ship_q;
        unique case (ship_q)
            CCR_SHIP_IDLE:
                if (switch_q[`CCR_B_SW_DISABLE])
                    ship_d = switch_q[`CCR_B_SW_DELAY] ? CCR_SHIP_WAIT
                                                       : CCR_SHIP_OFF;
            CCR_SHIP_WAIT:
                if (!switch_q[`CCR_B_SW_DISABLE])
                    ship_d = CCR_SHIP_IDLE;
                else if (ship_done)
                    ship_d = CCR_SHIP_OFF;
            CCR_SHIP_OFF:
                if (!switch_q[`CCR_B_SW_DISABLE])
                    ship_d = CCR_SHIP_IDLE;
            default: ship_d = CCR_SHIP_IDLE;
        endcase
        detect_d = switch_q[`CCR_B_FORCE_DETECT] && vbus_sync_q[1];
    end

    // Analog set points, registered so the outputs come from flops
    always_comb
    begin
        ovp_d = pick4(protect_q[`CCR_F_OVP_HI:`CCR_F_OVP_LO], `CCR_OVP_0_MV,
                      `CCR_OVP_1_MV, `CCR_OVP_2_MV, `CCR_OVP_3_MV);
        boost_d = pick4(protect_q[`CCR_F_BOOST_HI:`CCR_F_BOOST_LO], `CCR_BOOST_0_MV,
                        `CCR_BOOST_1_MV, `CCR_BOOST_2_MV, `CCR_BOOST_3_MV);
        // Offset select is a field of a register outside this block
        floor_reg_mv = 16'(pick4(input_floor_offset_select,
                                 `CCR_FLOOR_OS_0_MV, `CCR_FLOOR_OS_1_MV,
                                 `CCR_FLOOR_OS_2_MV,
                                 `CCR_FLOOR_OS_3_MV)
                           + `CCR_FLOOR_STEP_MV
                             * 16'(protect_q[`CCR_F_FLOOR_HI:`CCR_F_FLOOR_LO]));
        track_mv = 16'(vbat_mv + pick4(switch_q[`CCR_F_TRACK_HI:`CCR_F_TRACK_LO],
                                       16'h0000, `CCR_TRACK_1_MV, `CCR_TRACK_2_MV,
                                       `CCR_TRACK_3_MV));
        floor_d = (switch_q[`CCR_F_TRACK_HI:`CCR_F_TRACK_LO] != 2'h0
                   && track_mv > floor_reg_mv) ? track_mv : floor_reg_mv;
        cur_d = ichg_ma;
        if (cold_zone && cold_zone_current_enable)
            cur_d = 16'((32'(ichg_ma) * 32'(timer_wd_q[`CCR_B_COLD_SEL]
                                             ? `CCR_COLD_FIFTH_PCT
                                             : `CCR_COLD_HALF_PCT))
                        / 32'(`CCR_PCT_FULL));
        volt_d = vreg_mv;
        if (warm_zone && !switch_q[`CCR_B_WARM_SEL] && vreg_mv > `CCR_WARM_LIMIT_MV)
            volt_d = `CCR_WARM_LIMIT_MV;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ship_q      <= CCR_SHIP_IDLE;
            detect_q    <= 1'b0;
            ovp_q       <= 16'h0000;
            boost_q     <= 16'h0000;
            floor_q     <= 16'h0000;
            cur_q       <= 16'h0000;
            volt_q      <= 16'h0000;
            thermal_q   <= 1'b0;
            rst_allow_q <= 1'b0;
        end
        else
        begin
            ship_q      <= ship_d;
            detect_q    <= detect_d;
            ovp_q       <= ovp_d;
            boost_q     <= boost_d;
            floor_q     <= floor_d;
            cur_q       <= cur_d;
            volt_q      <= volt_d;
            thermal_q   <= timer_wd_q[`CCR_B_THERMAL_SEL];
            rst_allow_q <= switch_q[`CCR_B_SW_RST_EN];
        end
    end

    assign reg_rdata                    = rdata_q;
    assign termination_done             = deglitch_done;
    assign watchdog_expired             = wd_fire_q;
    assign safety_timer_expired         = safety_done;
    assign input_detect_run             = detect_q;
    assign battery_switch_off           = (ship_q == CCR_SHIP_OFF);
    assign battery_switch_reset_allowed = rst_allow_q;
    assign thermal_limit_select         = thermal_q;
    assign ovp_threshold_mv             = ovp_q;
    assign boost_mv                     = boost_q;
    assign input_floor_mv               = floor_q;
    assign charge_current_ma            = cur_q;
    assign charge_voltage_mv            = volt_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    wd_off_quiet_a: assert property ((wd_field == 2'h0) |-> !wd_fire_d)
        else $error("watchdog fired while disabled");
    wd_restore_a: assert property (wd_fire_q && !reg_reset_cmd
        |=> timer_wd_q == `CCR_RST_TIMER_WD
            && protect_q == $past(protect_q))
        else $error("watchdog restore wrong");
    ship_now_a: assert property ($rose(switch_q[`CCR_B_SW_DISABLE])
        && !switch_q[`CCR_B_SW_DELAY] && ship_q == CCR_SHIP_IDLE
        |=> battery_switch_off)
        else $error("switch not off at once");
    ship_wait_a: assert property (ship_q == CCR_SHIP_WAIT && !ship_done
        |=> !battery_switch_off)
        else $error("switch off before delay");
    detect_clear_a: assert property (detect_done && switch_q[`CCR_B_FORCE_DETECT]
        && !reg_write && !reg_reset_cmd |=> !switch_q[`CCR_B_FORCE_DETECT])
        else $error("detect bit not cleared");
    detect_run_a: assert property (switch_q[`CCR_B_FORCE_DETECT] && vbus_sync_q[1]
        |=> input_detect_run)
        else $error("detection not started");
    term_gate_a: assert property (!timer_wd_q[`CCR_B_TERM_EN]
        |=> !termination_done)
        else $error("termination while disabled");
    warm_limit_a: assert property (warm_zone && !switch_q[`CCR_B_WARM_SEL]
        |=> charge_voltage_mv <= `CCR_WARM_LIMIT_MV)
        else $error("warm voltage not limited");
    floor_track_a: assert property (switch_q[`CCR_F_TRACK_HI:`CCR_F_TRACK_LO] == 2'h0
        |=> input_floor_mv == $past(floor_reg_mv))
        else $error("floor not from register");
    safety_gate_a: assert property (!timer_wd_q[`CCR_B_TIMER_EN]
        |=> !safety_timer_expired)
        else $error("safety timer while disabled");
endmodule : ccr_control_regs
`default_nettype wire

// [verif/ccr_host_model.sv]
/*
 * Host side of the register strobe port: byte writes and reads.
 * Assumes one calling process and the one-cycle strobe contract.
 */
`timescale 1ns/100ps
`default_nettype none
module ccr_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_write,
    output var  logic       reg_read
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        // Idle data bus flips so a stale byte cannot pass as fresh
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : ccr_host_model
`default_nettype wire

// [verif/ccr_control_regs_tb.sv]
/*
 * Self-checking bench of the charger control registers 5 to 7.
 * Assumes ccr_host_model drives the register port, ticks of one clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g); \
        end \
    end
module ccr_control_regs_tb;
    logic              clk, reset_n, vbus_present_pin, detect_done;
    logic              cold_zone, cold_zone_current_enable, warm_zone;
    logic              reg_reset_cmd, watchdog_kick, term_condition_pin;
    logic [1:0]        input_floor_offset_select;
    logic [15:0]       ichg_ma, vreg_mv, vbat_mv;
    wire  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire  logic        reg_write, reg_read, input_detect_run, battery_switch_off;
    wire  logic        battery_switch_reset_allowed, termination_done;
    wire  logic        watchdog_expired, thermal_limit_select;
    wire  logic [15:0] ovp_threshold_mv, boost_mv, input_floor_mv;
    wire  logic [15:0] charge_current_ma, charge_voltage_mv;
    int                n_errors = 0, checks_done = 0;
    logic [7:0]        rv;
    ccr_control_regs #(.TICK_CYCLES(1)) i_ccr_control_regs (
        .clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .reg_reset_cmd, .watchdog_kick, .vbus_present_pin,
        .term_condition_pin, .charging_active(1'b0), .slow_condition(1'b0),
        .detect_done, .cold_zone, .cold_zone_current_enable, .warm_zone, .ichg_ma,
        .vreg_mv, .vbat_mv, .input_floor_offset_select, .termination_done,
        .watchdog_expired, .safety_timer_expired(), .input_detect_run,
        .battery_switch_off, .battery_switch_reset_allowed, .thermal_limit_select,
        .ovp_threshold_mv, .boost_mv, .input_floor_mv, .charge_current_ma,
        .charge_voltage_mv
    );
    ccr_host_model i_ccr_host_model (
        .clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_ccr_host_model.wr(a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_ccr_host_model.rd(a, d);
    endtask : rd
    task automatic t_reset;
        logic [7:0] adr [4] = '{8'h05, 8'h06, 8'h07, 8'h09};
        logic [7:0] exv [4] = '{8'hBF, 8'hE6, 8'h4C, 8'h00};
        for (int k = 0; k < 4; k++)
        begin
            rd(adr[k], rv);
            `CHK("reg", exv[k], rv)
        end
        `CHK("rst_en", 1'b1, battery_switch_reset_allowed)
    endtask : t_reset
    task automatic t_codes;
        logic [15:0] ovp [4] = '{16'd5500, 16'd6500, 16'd10500, 16'd14000};
        logic [15:0] bst [4] = '{16'd4850, 16'd5000, 16'd5150, 16'd5300};
        logic [15:0] trk [4] = '{16'd4500, 16'd4600, 16'd4650, 16'd4700};
        logic [15:0] ofs [4] = '{16'd4500, 16'd6500, 16'd8100, 16'd11100};
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h06, {k[1:0], k[1:0], 4'(k * 5)});
            cyc(2);
            `CHK("ovp", ovp[k], ovp_threshold_mv)
            `CHK("boost", bst[k], boost_mv)
            `CHK("floor", 16'(3900 + 500 * k), input_floor_mv)
        end
        wr(8'h06, 8'hE6);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h07, {6'h13, k[1:0]});
            cyc(2);
            `CHK("track", trk[k], input_floor_mv)
        end
        wr(8'h07, 8'h4C);
        for (int k = 1; k < 4; k++)
        begin
            @(posedge clk);
            input_floor_offset_select <= k[1:0];
            cyc(2);
            `CHK("offset", ofs[k], input_floor_mv)
        end
        @(posedge clk);
        input_floor_offset_select <= 2'h0;
    endtask : t_codes
    task automatic t_zones;
        @(posedge clk);
        cold_zone <= 1'b1;
        cold_zone_current_enable <= 1'b1;
        cyc(2);
        `CHK("cold", 16'd200, charge_current_ma)
        wr(8'h05, 8'hBE);
        cyc(2);
        `CHK("cold", 16'd500, charge_current_ma)
        @(posedge clk);
        cold_zone <= 1'b0;
        warm_zone <= 1'b1;
        cyc(2);
        `CHK("warm", 16'd4100, charge_voltage_mv)
        wr(8'h07, 8'h58);
        cyc(2);
        `CHK("warm", 16'd4200, charge_voltage_mv)
        `CHK("rst_en", 1'b0, battery_switch_reset_allowed)
        wr(8'h07, 8'h4C);
    endtask : t_zones
    task automatic t_detect;
        @(posedge clk);
        vbus_present_pin <= 1'b1;
        cyc(3);
        wr(8'h07, 8'hCC);
        cyc(3);
        `CHK("det_run", 1'b1, input_detect_run)
        @(posedge clk);
        detect_done <= 1'b1;
        @(posedge clk);
        detect_done <= 1'b0;
        rd(8'h07, rv);
        `CHK("det_bit", 8'h4C, rv)
        `CHK("det_run", 1'b0, input_detect_run)
    endtask : t_detect
    task automatic t_ship;
        wr(8'h07, 8'h64);
        cyc(3);
        `CHK("sw_off", 1'b1, battery_switch_off)
        wr(8'h07, 8'h4C);
        cyc(3);
        wr(8'h07, 8'h6C);
        // 12000 ticks of one clock, off two cycles later
        cyc(11950);
        `CHK("sw_off", 1'b0, battery_switch_off)
        cyc(100);
        `CHK("sw_off", 1'b1, battery_switch_off)
    endtask : t_ship
    task automatic t_wdog;
        wr(8'h07, 8'h1B);
        wr(8'h05, 8'h9D);
        @(posedge clk);
        watchdog_kick <= 1'b1;
        @(posedge clk);
        watchdog_kick <= 1'b0;
        // Kick restarts the count, expiry near 40000 ticks
        cyc(39990);
        `CHK("wd_early", 1'b0, watchdog_expired)
        `CHK("thermal", 1'b0, thermal_limit_select)
        for (int n = 0; n < 20 && watchdog_expired !== 1'b1; n++)
            cyc(1);
        `CHK("wd_fire", 1'b1, watchdog_expired)
        rd(8'h05, rv);
        `CHK("wd_r5", 8'hBF, rv)
        rd(8'h06, rv);
        `CHK("wd_r6", 8'hE6, rv)
        rd(8'h07, rv);
        `CHK("wd_r7", 8'h4F, rv)
        `CHK("thermal", 1'b1, thermal_limit_select)
    endtask : t_wdog
    task automatic t_regrst;
        wr(8'h06, 8'h00);
        @(posedge clk);
        reg_reset_cmd <= 1'b1;
        @(posedge clk);
        reg_reset_cmd <= 1'b0;
        rd(8'h06, rv);
        `CHK("rr_r6", 8'hE6, rv)
        `CHK("rr_ovp", 16'd14000, ovp_threshold_mv)
        rd(8'h07, rv);
        `CHK("rr_r7", 8'h4C, rv)
    endtask : t_regrst
    task automatic t_term;
        wr(8'h05, 8'hFF);
        @(posedge clk);
        term_condition_pin <= 1'b1;
        // Two sync stages plus 16 ticks
        cyc(10);
        `CHK("term", 1'b0, termination_done)
        cyc(10);
        `CHK("term", 1'b1, termination_done)
        @(posedge clk);
        term_condition_pin <= 1'b0;
        cyc(4);
        `CHK("term", 1'b0, termination_done)
    endtask : t_term
    task automatic tally_and_finish;
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #700000;
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        reset_n = 1'b0;
        vbus_present_pin = 1'b0;
        detect_done = 1'b0;
        reg_reset_cmd = 1'b0;
        watchdog_kick = 1'b0;
        term_condition_pin = 1'b0;
        input_floor_offset_select = 2'h0;
        cold_zone = 1'b0;
        cold_zone_current_enable = 1'b0;
        warm_zone = 1'b0;
        ichg_ma = 16'd1000;
        vreg_mv = 16'd4200;
        vbat_mv = 16'd4400;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        cyc(2);
        t_reset();
        t_codes();
        t_zones();
        t_detect();
        t_ship();
        t_wdog();
        t_regrst();
        t_term();
        tally_and_finish();
    end
endmodule : ccr_control_regs_tb
`default_nettype wire
